// ### hdl/ipms_flags.sv
// Sticky flag bank: pending and miss flags of sources 1 to 15.
// Assumes single-cycle event pulses on the system clock.
`timescale 1ns/1ps
module ipms_flags
    import ipms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] event_in,
    input wire logic [15:0] ack_pend,
    input wire logic [15:0] ack_miss,
    output logic [15:0] pend_ff,
    output logic [15:0] miss_ff
);
    logic [15:0] nxt_pend;
    logic [15:0] nxt_miss;

    // Event wins over a clearing write in the same cycle
    always_comb begin
        nxt_pend = ((pend_ff & ~ack_pend) | event_in)
                   & IPMS_IMPL_MASK;
        nxt_miss = ((miss_ff & ~ack_miss) | (event_in & pend_ff))
                   & IPMS_IMPL_MASK;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pend_ff <= IPMS_RST_PEND;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            miss_ff <= IPMS_RST_MISS;
        end else begin
            miss_ff <= nxt_miss;
        end
    end
endmodule

// ### hdl/ipms_pkg.sv
// Package for the interrupt pending, miss and software trigger block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package ipms_pkg;
    // Printed offsets are not all multiples of four: they are indices
    localparam logic [15:0] IPMS_IDX_PEND = 16'h4600;
    localparam logic [15:0] IPMS_IDX_MISS = 16'h4602;
    localparam logic [15:0] IPMS_IDX_SWTRIG = 16'h4638;
    localparam logic [15:0] IPMS_IDX_TOPEN = 16'h4680;
    localparam logic [15:0] IPMS_IDX_GLBEN = 16'h4681;
    localparam logic [15:0] IPMS_IDX_ISTAT = 16'h4682;
    localparam logic [15:0] IPMS_IDX_IMASK = 16'h4683;
    localparam logic [17:0] IPMS_ADDR_PEND = {IPMS_IDX_PEND, 2'b00};
    localparam logic [17:0] IPMS_ADDR_MISS = {IPMS_IDX_MISS, 2'b00};
    localparam logic [17:0] IPMS_ADDR_SWTRIG = {IPMS_IDX_SWTRIG, 2'b00};
    localparam logic [17:0] IPMS_ADDR_TOPEN = {IPMS_IDX_TOPEN, 2'b00};
    localparam logic [17:0] IPMS_ADDR_GLBEN = {IPMS_IDX_GLBEN, 2'b00};
    localparam logic [17:0] IPMS_ADDR_ISTAT = {IPMS_IDX_ISTAT, 2'b00};
    localparam logic [17:0] IPMS_ADDR_IMASK = {IPMS_IDX_IMASK, 2'b00};

    localparam int IPMS_BIT_SW = 1;
    localparam int IPMS_BIT_DBG = 2;
    localparam int IPMS_BIT_SLEEP = 4;
    localparam int IPMS_BIT_SEC = 7;
    localparam int IPMS_BIT_MACRX = 10;

    localparam logic [15:0] IPMS_RST_PEND = 16'h0000;
    localparam logic [15:0] IPMS_RST_MISS = 16'h0000;
    localparam logic [15:0] IPMS_RST_SWTRIG = 16'h0000;
    localparam logic [15:0] IPMS_RST_TOPEN = 16'h0000;
    localparam logic IPMS_RST_GLBEN = 1'b0;
    localparam logic [31:0] IPMS_RST_PRDATA = 32'h00000000;
    localparam logic [2:0] IPMS_RST_ISTAT = 3'h0;
    localparam logic [2:0] IPMS_RST_IMASK = 3'h0;
    // System-peripheral bits: writes ignored in application mode
    localparam logic [15:0] IPMS_SYS_MASK = 16'hc79e;
    // Bit 0 is hard zero
    localparam logic [15:0] IPMS_IMPL_MASK = 16'hfffe;
    // Local event bits in the interrupt status register
    localparam int IPMS_EV_PEND = 0;
    localparam int IPMS_EV_MISS = 1;
    localparam int IPMS_EV_SWTRIG = 2;
endpackage

// ### hdl/ipms_top.sv
// Top-level interrupt pending/miss flags with software trigger, APB slave.
// Assumes event pulses synchronous to clk_sys; app_mode is a pin input.
`timescale 1ns/1ps
module ipms_top
    import ipms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] event_in,
    input wire logic app_mode,
    output logic cpu_irq,
    output logic block_irq
);
    logic app_meta_ff;
    logic app_sync_ff;
    logic [15:0] pend_ff;
    logic [15:0] miss_ff;
    logic [15:0] swtrig_ff;
    logic [15:0] nxt_swtrig;
    logic sw_evt_ff;
    logic nxt_sw_evt;
    logic [15:0] topen_ff;
    logic [15:0] nxt_topen;
    logic glben_ff;
    logic nxt_glben;
    logic [2:0] istat_ff;
    logic [2:0] nxt_istat;
    logic [2:0] imask_ff;
    logic [2:0] nxt_imask;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic cpu_irq_ff;
    logic nxt_cpu_irq;
    logic block_irq_ff;
    logic nxt_block_irq;
    logic sel_pend;
    logic sel_miss;
    logic sel_swtrig;
    logic sel_topen;
    logic sel_glben;
    logic sel_istat;
    logic sel_imask;
    logic mapped;
    logic setup;
    logic access;
    logic rd_setup;
    logic wr_go;
    logic wr_pend;
    logic wr_miss;
    logic wr_swtrig;
    logic wr_topen;
    logic wr_glben;
    logic wr_istat;
    logic wr_imask;
    logic [15:0] wmask;
    logic [15:0] ack_pend;
    logic [15:0] ack_miss;
    logic [15:0] all_events;
    logic [15:0] live_events;
    logic [15:0] pend_enabled;
    logic [2:0] ev_now;
    logic [2:0] istat_enabled;

    // True when a bus address selects one register word
    function automatic logic hit(input logic [31:0] a,
                                 input logic [17:0] r);
        hit = (a[31:18] == 14'h0000) && (a[17:0] == r);
    endfunction

    // Zero-extends a 16-bit register into a bus word
    function automatic logic [31:0] word16(input logic [15:0] v);
        word16 = {16'h0000, v};
    endfunction

    // Zero-extends a 3-bit register into a bus word
    function automatic logic [31:0] word3(input logic [2:0] v);
        word3 = {29'h00000000, v};
    endfunction

    // Keeps the locked bits of a register, takes the rest from a write
    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [15:0] wr,
                                            input logic [15:0] keep);
        merge16 = (cur & keep) | (wr & ~keep);
    endfunction

    // Application mode comes from the core, outside this clock tree
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            app_meta_ff <= 1'b0;
        end else begin
            app_meta_ff <= app_mode;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            app_sync_ff <= 1'b0;
        end else begin
            app_sync_ff <= app_meta_ff;
        end
    end

    // Register decode, shared by the write strobes and the read mux
    assign sel_pend = hit(paddr, IPMS_ADDR_PEND);
    assign sel_miss = hit(paddr, IPMS_ADDR_MISS);
    assign sel_swtrig = hit(paddr, IPMS_ADDR_SWTRIG);
    assign sel_topen = hit(paddr, IPMS_ADDR_TOPEN);
    assign sel_glben = hit(paddr, IPMS_ADDR_GLBEN);
    assign sel_istat = hit(paddr, IPMS_ADDR_ISTAT);
    assign sel_imask = hit(paddr, IPMS_ADDR_IMASK);
    assign mapped = sel_pend || sel_miss || sel_swtrig || sel_topen
                    || sel_glben || sel_istat || sel_imask;

    // Setup samples the request; access is the cycle in which pready stands
    assign setup = psel && !penable;
    assign access = psel && penable && pready_ff;
    assign rd_setup = setup && !pwrite;
    // Zero-wait-state slave: a write lands at the edge that ends access
    assign wr_go = access && pwrite && mapped;
    assign wr_pend = wr_go && sel_pend;
    assign wr_miss = wr_go && sel_miss;
    assign wr_swtrig = wr_go && sel_swtrig;
    assign wr_topen = wr_go && sel_topen;
    assign wr_glben = wr_go && sel_glben;
    assign wr_istat = wr_go && sel_istat;
    assign wr_imask = wr_go && sel_imask;

    // System bits are locked while in application mode
    assign wmask = app_sync_ff ? (IPMS_IMPL_MASK & ~IPMS_SYS_MASK)
                               : IPMS_IMPL_MASK;
    assign ack_pend = wr_pend ? (pwdata[15:0] & wmask)
                              : 16'h0000;
    assign ack_miss = wr_miss ? (pwdata[15:0] & wmask)
                              : 16'h0000;
    // The software event enters the bank at its own bit
    assign all_events = event_in | {14'h0000, sw_evt_ff, 1'b0};
    assign live_events = all_events & IPMS_IMPL_MASK;

    ipms_flags u_flags (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .event_in(all_events),
        .ack_pend(ack_pend),
        .ack_miss(ack_miss),
        .pend_ff(pend_ff),
        .miss_ff(miss_ff)
    );

    // Software trigger: any write, any value, pulses the software event
    always_comb begin
        nxt_swtrig = swtrig_ff;
        if (wr_swtrig) begin
            nxt_swtrig = pwdata[15:0];
        end
    end

    assign nxt_sw_evt = wr_swtrig;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            swtrig_ff <= IPMS_RST_SWTRIG;
        end else begin
            swtrig_ff <= nxt_swtrig;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sw_evt_ff <= 1'b0;
        end else begin
            sw_evt_ff <= nxt_sw_evt;
        end
    end

    // Top-level enables: system bits locked in application mode
    always_comb begin
        nxt_topen = topen_ff;
        if (wr_topen) begin
            nxt_topen = merge16(topen_ff, pwdata[15:0], ~wmask);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            topen_ff <= IPMS_RST_TOPEN;
        end else begin
            topen_ff <= nxt_topen;
        end
    end

    // Global enable gates every source at once into cpu_irq only; block_irq is not gated
    always_comb begin
        nxt_glben = glben_ff;
        if (wr_glben) begin
            nxt_glben = pwdata[0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            glben_ff <= IPMS_RST_GLBEN;
        end else begin
            glben_ff <= nxt_glben;
        end
    end

    // Local events: new pending, new miss, software trigger
    always_comb begin
        ev_now = 3'h0;
        ev_now[IPMS_EV_PEND] = |(live_events & ~pend_ff);
        ev_now[IPMS_EV_MISS] = |(live_events & pend_ff);
        ev_now[IPMS_EV_SWTRIG] = sw_evt_ff;
    end

    // Status bits: write one to clear, a new event wins over the clear
    always_comb begin
        nxt_istat = istat_ff | ev_now;
        if (wr_istat) begin
            nxt_istat = (istat_ff & ~pwdata[2:0]) | ev_now;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            istat_ff <= IPMS_RST_ISTAT;
        end else begin
            istat_ff <= nxt_istat;
        end
    end

    always_comb begin
        nxt_imask = imask_ff;
        if (wr_imask) begin
            nxt_imask = pwdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            imask_ff <= IPMS_RST_IMASK;
        end else begin
            imask_ff <= nxt_imask;
        end
    end

    // Processor interrupt: global enable and one enabled pending flag
    assign pend_enabled = pend_ff & topen_ff;
    assign nxt_cpu_irq = glben_ff && (|pend_enabled);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cpu_irq_ff <= 1'b0;
        end else begin
            cpu_irq_ff <= nxt_cpu_irq;
        end
    end

    // Block interrupt: any unmasked local status bit
    assign istat_enabled = istat_ff & imask_ff;
    assign nxt_block_irq = |istat_enabled;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            block_irq_ff <= 1'b0;
        end else begin
            block_irq_ff <= nxt_block_irq;
        end
    end

    // APB answer: ready and error stand in the cycle after setup
    assign nxt_pready = setup;
    assign nxt_pslverr = setup && !mapped;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Read data are captured at setup and stand through access
    always_comb begin
        nxt_prdata = prdata_ff;
        if (rd_setup) begin
            if (sel_pend) begin
                nxt_prdata = word16(pend_ff & IPMS_IMPL_MASK);
            end else if (sel_miss) begin
                nxt_prdata = word16(miss_ff & IPMS_IMPL_MASK);
            end else if (sel_swtrig) begin
                nxt_prdata = word16(swtrig_ff);
            end else if (sel_topen) begin
                nxt_prdata = word16(topen_ff);
            end else if (sel_glben) begin
                nxt_prdata = {31'h00000000, glben_ff};
            end else if (sel_istat) begin
                nxt_prdata = word3(istat_ff);
            end else if (sel_imask) begin
                nxt_prdata = word3(imask_ff);
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff <= IPMS_RST_PRDATA;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_irq = cpu_irq_ff;
    assign block_irq = block_irq_ff;
endmodule

// ### test/ipms_src_model.sv
// Event source model: one single-cycle pulse of mask, dly cycles after go.
// Assumes go is a one-cycle request on clk_sys and dly is at least 1.
`timescale 1ns/1ps
module ipms_src_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic go,
    input wire logic [3:0] dly,
    input wire logic [15:0] mask,
    output logic [15:0] event_in
);
    logic [3:0] cnt_ff;
    logic [15:0] mask_ff;
    logic [15:0] ev_ff;
    assign event_in = ev_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 4'h0;
            mask_ff <= 16'h0000;
            ev_ff <= 16'h0000;
        end else begin
            if (go) begin
                cnt_ff <= dly;
                mask_ff <= mask;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
            ev_ff <= (cnt_ff == 4'h1) ? mask_ff : 16'h0000;
        end
    end
endmodule

// ### test/ipms_top_bench.sv
// Self-checking bench of ipms_top: APB master, event source, irq checks.
// Assumes the checker is bound below and reads answer one cycle after setup.
`timescale 1ns/1ps
module ipms_top_bench
    import ipms_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, app_mode = 1'b0;
    logic go = 1'b0, pready, pslverr, cpu_irq, block_irq;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rnd = 32'hd;
    logic [15:0] event_in, ev_mask = 16'h0, ev;
    logic [3:0] dly = 4'h1;
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    int num_errors = 0, total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    ipms_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_in(event_in), .app_mode(app_mode), .cpu_irq(cpu_irq),
        .block_irq(block_irq));
    ipms_src_model src (.clk_sys(clk_sys), .reset_n(reset_n), .go(go),
        .dly(dly), .mask(ev_mask), .event_in(event_in));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, a};
        pwdata <= d;
        exp_q.push_back({!w, e});
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            end_of_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [17:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0, d}, 33'h0);
    endtask
    task rd(input logic [17:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0, {17'h0, e});
    endtask
    task fire(input logic [15:0] m, input logic [3:0] d);
        @(posedge clk_sys);
        go <= 1'b1;
        ev_mask <= m;
        dly <= d;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    // Scoreboard: oldest note against each completed transfer
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            e_m = exp_q.pop_front();
            chk({pslverr, e_m[33] ? prdata : 32'h0}, e_m[32:0]);
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(IPMS_ADDR_PEND, 16'h0);
        rd(IPMS_ADDR_MISS, 16'h0);
        rd(IPMS_ADDR_SWTRIG, 16'h0);
        apb(1'b0, 18'h00010, 32'h0, {1'b1, 32'h0});
        rnd = xs(rnd);
        ev = rnd[15:0] | 16'h04b7;
        fire(ev, {1'b0, rnd[18:16]} + 4'h1);
        repeat (10) @(posedge clk_sys);
        rd(IPMS_ADDR_PEND, ev & IPMS_IMPL_MASK);
        rd(IPMS_ADDR_MISS, 16'h0);
        fire(ev, 4'h1);
        repeat (4) @(posedge clk_sys);
        rd(IPMS_ADDR_MISS, ev & IPMS_IMPL_MASK);
        wr(IPMS_ADDR_PEND, 16'h0);
        rd(IPMS_ADDR_PEND, ev & IPMS_IMPL_MASK);
        app_mode <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wr(IPMS_ADDR_PEND, 16'hffff);
        wr(IPMS_ADDR_MISS, 16'hffff);
        ev = ev & IPMS_IMPL_MASK & IPMS_SYS_MASK;
        rd(IPMS_ADDR_PEND, ev);
        rd(IPMS_ADDR_MISS, ev);
        app_mode <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wr(IPMS_ADDR_PEND, 16'hffff);
        wr(IPMS_ADDR_MISS, 16'hffff);
        rd(IPMS_ADDR_PEND, 16'h0);
        rd(IPMS_ADDR_MISS, 16'h0);
        fire(16'h0800, 4'h1);
        repeat (4) @(posedge clk_sys);
        fork
            fire(16'h0800, 4'h1);
            begin
                @(posedge clk_sys);
                wr(IPMS_ADDR_PEND, 16'h0800);
            end
        join
        repeat (4) @(posedge clk_sys);
        rd(IPMS_ADDR_PEND, 16'h0800);
        rd(IPMS_ADDR_MISS, 16'h0800);
        wr(IPMS_ADDR_PEND, 16'hffff);
        wr(IPMS_ADDR_MISS, 16'hffff);
        wr(IPMS_ADDR_TOPEN, 16'h0002);
        wr(IPMS_ADDR_GLBEN, 16'h0001);
        wr(IPMS_ADDR_ISTAT, 16'h0007);
        rnd = xs(rnd);
        wr(IPMS_ADDR_SWTRIG, rnd[15:0]);
        repeat (4) @(posedge clk_sys);
        rd(IPMS_ADDR_PEND, 16'h0002);
        rd(IPMS_ADDR_SWTRIG, rnd[15:0]);
        chk({32'h0, cpu_irq}, 33'h1);
        wr(IPMS_ADDR_IMASK, 16'h0007);
        repeat (2) @(posedge clk_sys);
        chk({32'h0, block_irq}, 33'h1);
        wr(IPMS_ADDR_IMASK, 16'h0000);
        repeat (2) @(posedge clk_sys);
        chk({32'h0, block_irq}, 33'h0);
        wr(IPMS_ADDR_ISTAT, 16'h0007);
        wr(IPMS_ADDR_IMASK, 16'h0007);
        repeat (2) @(posedge clk_sys);
        chk({32'h0, block_irq}, 33'h0);
        wr(IPMS_ADDR_GLBEN, 16'h0000);
        repeat (2) @(posedge clk_sys);
        chk({32'h0, cpu_irq}, 33'h0);
        wr(IPMS_ADDR_SWTRIG, 16'h0000);
        repeat (4) @(posedge clk_sys);
        rd(IPMS_ADDR_MISS, 16'h0002);
        end_of_test;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        end_of_test;
    end
endmodule
bind ipms_top ipms_top_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .app_mode(app_mode), .cpu_irq(cpu_irq),
    .block_irq(block_irq));

// ### test/ipms_top_checker.sv
// Checker of the APB answers and the cpu_irq output of ipms_top.
// Assumes a bind to ipms_top and a bus master that keeps paddr[31:18] zero.
`timescale 1ns/1ps
module ipms_top_checker
    import ipms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] event_in,
    input wire logic app_mode,
    input wire logic cpu_irq,
    input wire logic block_irq
);
    logic glb_ff;
    logic en1_ff;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire rd_ok = pready && !pwrite;
    // Shadows of the global enable and the software source enable
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            glb_ff <= 1'b0;
        end else if (wr_ok && paddr[17:0] == IPMS_ADDR_GLBEN) begin
            glb_ff <= pwdata[0];
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en1_ff <= 1'b0;
        end else if (wr_ok && !app_mode
                     && paddr[17:0] == IPMS_ADDR_TOPEN) begin
            en1_ff <= pwdata[1];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_trig_write;
        wr_ok && paddr[17:0] == IPMS_ADDR_SWTRIG && glb_ff && en1_ff;
    endsequence
    a_trig_raises_irq: assert property (
        s_trig_write |-> ##[1:5] cpu_irq)
        else $error("trigger write did not raise cpu_irq");
    a_irq_glb_off: assert property (
        !glb_ff && !$past(glb_ff) |-> !cpu_irq)
        else $error("cpu_irq high with global enable off");
    a_bit0_reads_zero: assert property (
        rd_ok && (paddr[17:0] == IPMS_ADDR_PEND
        || paddr[17:0] == IPMS_ADDR_MISS) |-> !prdata[0])
        else $error("flag bit 0 read as one");
    a_upper_half_zero: assert property (rd_ok |-> prdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready in access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_reads_zero: assert property (rd_ok && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
endmodule
